// [logic/hpc_params.svh]
`ifndef HPC_PARAMS_SVH
`define HPC_PARAMS_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define HPC_OFS_CHARGE    8'h06
`define HPC_OFS_REMOVABLE 8'h07
`define HPC_OFS_USED      8'h08

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define HPC_FIELD_MSB     3
`define HPC_OVERRIDE_BIT  7

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define HPC_RST_USED      4'hF
`define HPC_RST_NIBBLE    4'h0

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
// Cycles for the strap synchroniser to fill after reset release
`define HPC_SETTLE_CYCLES 3'h4

`endif

// [logic/hpc_pkg.sv]
`default_nettype none

package hpc_pkg;

  typedef logic [3:0] hpc_nib_t;
  typedef logic [7:0] hpc_byte_t;

  typedef enum logic [1:0] {
    HPC_ST_SETTLE  = 2'b00,
    HPC_ST_CAPTURE = 2'b01,
    HPC_ST_RUN     = 2'b10
  } hpc_state_t;

endpackage : hpc_pkg

`default_nettype wire

// [logic/hpc_sync_if.sv]
`timescale 1ns/1ns
`default_nettype none

interface hpc_sync_if;
  hpc_pkg::hpc_nib_t raw;
  hpc_pkg::hpc_nib_t stable;

  modport owner (output raw, input stable);
  modport sync (input raw, output stable);
endinterface : hpc_sync_if

`default_nettype wire

// [logic/hpc_strap_sync.sv]
`timescale 1ns/1ns
`default_nettype none
`include "hpc_params.svh"

module hpc_strap_sync (
  // Clock and reset
  input wire logic clk_i,
  input wire logic arst_n_i,
  // Strap levels
  hpc_sync_if.sync sif
);

  hpc_pkg::hpc_nib_t s1_reg;
  hpc_pkg::hpc_nib_t s2_reg;
  hpc_pkg::hpc_nib_t s3_reg;
  hpc_pkg::hpc_nib_t stable_reg;

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      s1_reg <= `HPC_RST_NIBBLE;
      s2_reg <= `HPC_RST_NIBBLE;
      s3_reg <= `HPC_RST_NIBBLE;
    end else begin
      s1_reg <= sif.raw;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  // A bit changes only once the last two stages agree
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      stable_reg <= `HPC_RST_NIBBLE;
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (s2_reg[i] == s3_reg[i]) begin
          stable_reg[i] <= s3_reg[i];
        end
      end
    end
  end

  assign sif.stable = stable_reg;

endmodule : hpc_strap_sync

`default_nettype wire

// [logic/hpc_port_cfg.sv]
// How it works
// (RL1) Bits 6:4 of charge/removable read zero; bit 7 also zero on charge, override on removable
// (RL2) Charge bit n enables port n+1 charging
// (RL3) Charge bits captured from straps after reset
// (RL4) Config mode lets writes replace charge bits
// (RL5) Override bit gates removable flag writes
// (RL6) One write sets override and flags together
// (RL7) Removable bit n describes port n+1
// (RL8) Override clear: flags read as inverted fixed bits
// (RL9) Used bits enable ports, reset to ones
// (RL10) Used bit n governs port n+1
// (RL11) Configurer never disables ports one and three together
// (RL12) Override clear: flag writes are ignored
`timescale 1ns/1ns
`default_nettype none
`include "hpc_params.svh"

module hpc_port_cfg (
  // Clock and reset
  input wire logic clk_i,
  input wire logic arst_n_i,
  // Pins and fixed memory
  input wire logic [3:0] power_charge_strap_pins_i,
  input wire logic cfg_mode_i,
  input wire logic [3:0] otp_fixed_dev_i,
  // Register access from EEPROM loader or SMBus slave
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  output logic [7:0] reg_rdata_o,
  output logic reg_rvalid_o,
  // Port settings
  output logic [3:0] charge_enable_bits_o,
  output logic [3:0] port_removable_o,
  output logic [3:0] port_used_o,
  output logic removable_override_enable_o
);

  // ----------------------------------------------------------------
  // Strap capture
  // ----------------------------------------------------------------
  hpc_sync_if sif ();
  assign sif.raw = power_charge_strap_pins_i;

  hpc_strap_sync u_sync (
    .clk_i(clk_i),
    .arst_n_i(arst_n_i),
    .sif(sif)
  );

  // Mode pin is a strap too; 3-stage path, last two stages must agree
  logic [2:0] mode_sync_reg;
  logic mode_reg;
  hpc_pkg::hpc_state_t state_reg;
  logic [2:0] settle_reg;

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      mode_sync_reg <= 3'h0;
      mode_reg <= 1'b0;
    end else begin
      mode_sync_reg <= {mode_sync_reg[1:0], cfg_mode_i};
      if (mode_sync_reg[1] == mode_sync_reg[2]) begin
        mode_reg <= mode_sync_reg[2];
      end
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_reg <= hpc_pkg::HPC_ST_SETTLE;
      settle_reg <= 3'h0;
    end else begin
      case (state_reg)
        hpc_pkg::HPC_ST_SETTLE: begin
          settle_reg <= settle_reg + 3'h1;
          if (settle_reg == `HPC_SETTLE_CYCLES) begin
            state_reg <= hpc_pkg::HPC_ST_CAPTURE;
          end
        end
        hpc_pkg::HPC_ST_CAPTURE: state_reg <= hpc_pkg::HPC_ST_RUN;
        hpc_pkg::HPC_ST_RUN: state_reg <= hpc_pkg::HPC_ST_RUN;
        default: state_reg <= hpc_pkg::HPC_ST_SETTLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Register storage
  // ----------------------------------------------------------------
  hpc_pkg::hpc_nib_t charge_reg;
  hpc_pkg::hpc_nib_t rmbl_reg;
  hpc_pkg::hpc_nib_t used_reg;
  logic override_reg;
  logic wr_ok;

  // Writes before the strap capture are dropped, not held, so they are not overwritten
  assign wr_ok = reg_wr_i && mode_reg && (state_reg == hpc_pkg::HPC_ST_RUN);

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      charge_reg <= `HPC_RST_NIBBLE;
    end else if (state_reg == hpc_pkg::HPC_ST_CAPTURE) begin
      charge_reg <= sif.stable; // RL3
    end else if (wr_ok && reg_addr_i == `HPC_OFS_CHARGE) begin
      charge_reg <= reg_wdata_i[`HPC_FIELD_MSB:0]; // RL4
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      override_reg <= 1'b0;
      rmbl_reg <= `HPC_RST_NIBBLE;
    end else if (wr_ok && reg_addr_i == `HPC_OFS_REMOVABLE) begin
      override_reg <= reg_wdata_i[`HPC_OVERRIDE_BIT];
      // New override value gates the flags in the same write
      if (reg_wdata_i[`HPC_OVERRIDE_BIT]) begin
        rmbl_reg <= reg_wdata_i[`HPC_FIELD_MSB:0]; // RL5 RL6 RL12
      end
    end
  end

  // Configurer must avoid disabling ports one and three together
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      used_reg <= `HPC_RST_USED; // RL9
    end else if (wr_ok && reg_addr_i == `HPC_OFS_USED) begin
      used_reg <= reg_wdata_i[`HPC_FIELD_MSB:0]; // RL9 RL11
    end
  end

  // ----------------------------------------------------------------
  // Read path and outputs
  // ----------------------------------------------------------------
  hpc_pkg::hpc_nib_t rmbl_view;
  hpc_pkg::hpc_byte_t rd_mux;

  assign rmbl_view = override_reg ? rmbl_reg : ~otp_fixed_dev_i; // RL8

  always_comb begin
    case (reg_addr_i)
      `HPC_OFS_CHARGE: rd_mux = {4'h0, charge_reg}; // RL1
      `HPC_OFS_REMOVABLE: rd_mux = {override_reg, 3'h0, rmbl_view}; // RL1
      `HPC_OFS_USED: rd_mux = {4'h0, used_reg};
      default: rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      reg_rdata_o <= 8'h00;
      reg_rvalid_o <= 1'b0;
    end else begin
      reg_rvalid_o <= reg_rd_i;
      if (reg_rd_i) begin
        reg_rdata_o <= rd_mux;
      end
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      charge_enable_bits_o <= `HPC_RST_NIBBLE;
      port_removable_o <= `HPC_RST_NIBBLE;
      port_used_o <= `HPC_RST_USED;
      removable_override_enable_o <= 1'b0;
    end else begin
      charge_enable_bits_o <= charge_reg; // RL2
      port_removable_o <= rmbl_view; // RL7
      port_used_o <= used_reg; // RL10
      removable_override_enable_o <= override_reg;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);

  sequence s_rmbl_wr_keep;
    wr_ok && reg_addr_i == `HPC_OFS_REMOVABLE && !override_reg
      && !reg_wdata_i[`HPC_OVERRIDE_BIT];
  endsequence

  sequence s_rmbl_wr_set;
    wr_ok && reg_addr_i == `HPC_OFS_REMOVABLE
      && reg_wdata_i[`HPC_OVERRIDE_BIT];
  endsequence

  property p_rsvd_zero;
    reg_rd_i && (reg_addr_i == `HPC_OFS_CHARGE
      || reg_addr_i == `HPC_OFS_REMOVABLE)
      |=> reg_rvalid_o && reg_rdata_o[6:4] == 3'h0
      && ($past(reg_addr_i) != `HPC_OFS_CHARGE || reg_rdata_o[7] == 1'b0);
  endproperty
  a_rsvd_zero: assert property (p_rsvd_zero) // RL1
    else $error("reserved read bits not zero");

  property p_charge_out;
    wr_ok && reg_addr_i == `HPC_OFS_CHARGE
      |-> ##2 charge_enable_bits_o == $past(reg_wdata_i[3:0], 2);
  endproperty
  a_charge_out: assert property (p_charge_out) // RL2
    else $error("charge enable output wrong after write");

  property p_strap_capture;
    state_reg == hpc_pkg::HPC_ST_CAPTURE |=> charge_reg == $past(sif.stable);
  endproperty
  a_strap_capture: assert property (p_strap_capture) // RL3
    else $error("strap value not captured");

  property p_mode_gate;
    reg_wr_i && !mode_reg && state_reg == hpc_pkg::HPC_ST_RUN
      |=> $stable(charge_reg) && $stable(used_reg);
  endproperty
  a_mode_gate: assert property (p_mode_gate) // RL4
    else $error("write accepted outside config mode");

  property p_rmbl_keep;
    s_rmbl_wr_keep |=> $stable(rmbl_reg) && !override_reg;
  endproperty
  a_rmbl_keep: assert property (p_rmbl_keep) // RL12
    else $error("removable flags written while locked");

  property p_rmbl_set;
    s_rmbl_wr_set |=> override_reg
      && rmbl_reg == $past(reg_wdata_i[3:0]) ##1
      port_removable_o == $past(reg_wdata_i[3:0], 2);
  endproperty
  a_rmbl_set: assert property (p_rmbl_set) // RL6
    else $error("combined override write not applied");

  property p_rmbl_inv;
    reg_rd_i && reg_addr_i == `HPC_OFS_REMOVABLE && !override_reg
      |=> reg_rdata_o[3:0] == ~$past(otp_fixed_dev_i);
  endproperty
  a_rmbl_inv: assert property (p_rmbl_inv) // RL8
    else $error("locked removable read not inverted");

  property p_used_reset;
    state_reg != hpc_pkg::HPC_ST_RUN |-> used_reg == 4'hF
      && port_used_o == 4'hF;
  endproperty
  a_used_reset: assert property (p_used_reset) // RL9
    else $error("port used not all ones after reset");

  property p_used_out;
    wr_ok && reg_addr_i == `HPC_OFS_USED
      |-> ##2 port_used_o == $past(reg_wdata_i[3:0], 2);
  endproperty
  a_used_out: assert property (p_used_out) // RL10
    else $error("port used output wrong after write");

endmodule : hpc_port_cfg

`default_nettype wire

// [verification/hpc_cfg_host.sv]
`timescale 1ns/1ns
`default_nettype none

// ----------------------------------------------------------------
// Configuration source: EEPROM loader or SMBus host
// ----------------------------------------------------------------
module hpc_cfg_host (
  // Clock
  input wire logic clk_i,
  // Register access
  output logic reg_wr_o,
  output logic reg_rd_o,
  output logic [7:0] reg_addr_o,
  output logic [7:0] reg_wdata_o,
  input wire logic [7:0] reg_rdata_i,
  input wire logic reg_rvalid_i
);
  initial begin
    reg_wr_o = 1'b0;
    reg_rd_o = 1'b0;
    reg_addr_o = 8'hFF;
    reg_wdata_o = 8'h00;
  end

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    // Ports one and three never both disabled by this source
    if (a == 8'h08 && d[0] == 1'b0 && d[2] == 1'b0) begin
      return;
    end
    @(negedge clk_i);
    reg_wr_o = 1'b1;
    reg_addr_o = a;
    reg_wdata_o = d;
    @(negedge clk_i);
    reg_wr_o = 1'b0;
    // Released lines must not keep the old value
    reg_addr_o = ~a;
    reg_wdata_o = ~d;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] d,
                    output logic ok);
    ok = 1'b0;
    d = 8'h00;
    @(negedge clk_i);
    reg_rd_o = 1'b1;
    reg_addr_o = a;
    @(negedge clk_i);
    reg_rd_o = 1'b0;
    reg_addr_o = ~a;
    // Bounded wait: a lost answer must not hang the run
    for (int n = 0; n < 8 && !ok; n++) begin
      if (reg_rvalid_i === 1'b1) begin
        d = reg_rdata_i;
        ok = 1'b1;
      end else begin
        @(negedge clk_i);
      end
    end
  endtask : rd
endmodule : hpc_cfg_host

`default_nettype wire

// [verification/tb_hpc_port_cfg.sv]
`timescale 1ns/1ns
`default_nettype none

module tb_hpc_port_cfg;
  logic clk_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic cfg_mode = 1'b1;
  logic [3:0] straps = 4'hA;
  logic [3:0] otp = 4'h3;
  logic wr, rd, rvalid, ovr;
  logic [7:0] addr, wdata, rdata;
  logic [3:0] charge, rmbl, used;
  int fails = 0;
  int cmp_count = 0;

`define CHECK(got, exp) \
  cmp_count++; \
  if ((got) !== (exp)) begin \
    $display("[ERR] %0t mismatch got %h exp %h", $time, got, exp); \
    fails++; \
  end

  initial begin
    forever #10 clk_i = ~clk_i;
  end

  hpc_cfg_host hpc_cfg_host_i (
    .clk_i(clk_i), .reg_wr_o(wr), .reg_rd_o(rd), .reg_addr_o(addr),
    .reg_wdata_o(wdata), .reg_rdata_i(rdata), .reg_rvalid_i(rvalid)
  );

  hpc_port_cfg hpc_port_cfg_i (
    .clk_i(clk_i), .arst_n_i(arst_n_i),
    .power_charge_strap_pins_i(straps), .cfg_mode_i(cfg_mode),
    .otp_fixed_dev_i(otp), .reg_wr_i(wr), .reg_rd_i(rd),
    .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_rdata_o(rdata),
    .reg_rvalid_o(rvalid), .charge_enable_bits_o(charge),
    .port_removable_o(rmbl), .port_used_o(used),
    .removable_override_enable_o(ovr)
  );

  // ----------------------------------------------------------------
  // Verdict
  // ----------------------------------------------------------------
  task automatic test_done();
    $display("Comparisons %0d, mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : test_done

  task automatic check_rd(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    logic ok;
    hpc_cfg_host_i.rd(a, d, ok);
    if (!ok) begin
      $display("[ERR] %0t read answer missing", $time);
      fails++;
      test_done();
    end else begin
      `CHECK(d, e)
    end
  endtask : check_rd

  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial begin
    logic [3:0] p;
    repeat (4) @(negedge clk_i);
    arst_n_i = 1'b1;
    repeat (12) @(negedge clk_i);
    check_rd(8'h06, 8'h0A);
    `CHECK(charge, 4'hA)
    check_rd(8'h08, 8'h0F);
    `CHECK(used, 4'hF)
    check_rd(8'h07, 8'h0C);
    `CHECK(rmbl, 4'hC)
    hpc_cfg_host_i.wr(8'h07, 8'h05);
    check_rd(8'h07, 8'h0C);
    hpc_cfg_host_i.wr(8'h07, 8'hFA);
    check_rd(8'h07, 8'h8A);
    `CHECK(rmbl, 4'hA)
    `CHECK(ovr, 1'b1)
    hpc_cfg_host_i.wr(8'h07, 8'h75);
    check_rd(8'h07, 8'h0C);
    `CHECK(ovr, 1'b0)
    otp = 4'h9;
    @(negedge clk_i);
    check_rd(8'h07, 8'h06);
    `CHECK(rmbl, 4'h6)
    for (int i = 0; i < 4; i++) begin
      p = 4'h1 << i;
      hpc_cfg_host_i.wr(8'h06, {4'hF, p});
      hpc_cfg_host_i.wr(8'h08, {4'hF, ~p});
      check_rd(8'h06, {4'h0, p});
      check_rd(8'h08, {4'h0, ~p});
      `CHECK(charge, p)
      `CHECK(used, ~p)
    end
    cfg_mode = 1'b0;
    repeat (6) @(negedge clk_i);
    hpc_cfg_host_i.wr(8'h06, 8'h03);
    check_rd(8'h06, 8'h08);
    cfg_mode = 1'b1;
    repeat (6) @(negedge clk_i);
    hpc_cfg_host_i.wr(8'h06, 8'h03);
    check_rd(8'h06, 8'h03);
    check_rd(8'h09, 8'h00);
    test_done();
  end
endmodule : tb_hpc_port_cfg

`default_nettype wire
